// file: dv/rtcf_flags_assertions.sv
// assertion checker for the rtc flags and control register
`timescale 1ns/1ps
module rtcf_flags_assertions
   import rtcf_pkg::*;
#(
   parameter longint SQW_HALF = SQW_HALF_CYC
)
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        wdog_zero,
   input wire logic [31:0] time_now,
   input wire logic [31:0] alarm_cfg,
   input wire logic        pfail_pin,
   input wire logic        osc_stopped_pin,
   input wire logic        int_normal,
   input wire logic        int_pin,
   input wire logic        write_hold,
   input wire logic        read_hold,
   input wire logic        hold_load
);
   // ---------------------------------------------------------------
   // helper logic
   // ---------------------------------------------------------------
   logic        tk, hit, rd0, wr0, calm, quiet;
   logic        wr_pend_r, cal_r, int_q_r, arm_r, tog_ok_r;
   logic [31:0] cnt_r;
   assign tk    = hsel && hready && htrans[1];
   assign hit   = haddr[7:0] == ADDR_FLAGS;
   assign rd0   = tk && !hwrite && hit;
   assign wr0   = tk && hwrite && hit;
   // events wait while hold is active and pending ones land just after release
   assign calm  = !write_hold && !hold_load && !wr_pend_r;
   assign quiet = calm && !wdog_zero;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         cal_r     <= 1'b0;
         int_q_r   <= 1'b0;
         arm_r     <= 1'b0;
         tog_ok_r  <= 1'b0;
         cnt_r     <= 32'h0000_0000;
      end else begin
         wr_pend_r <= wr0;
         if (wr_pend_r) begin
            cal_r <= hwdata[BIT_CAL];
         end
         int_q_r <= int_pin;
         if (int_pin != int_q_r) begin
            cnt_r    <= 32'h0000_0001;
            arm_r    <= cal_r;
            tog_ok_r <= arm_r && cal_r;
         end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
         end
         // the first half wave after enabling may be short
         if (!cal_r) begin
            arm_r    <= 1'b0;
            tog_ok_r <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_gap_rd;
      (!rd0 && quiet) [*2] ##1 rd0;
   endsequence
   sequence s_wd_beat;
      (wdog_zero && rd0 && calm) ##1 (!rd0 && calm) [*2] ##1 rd0;
   endsequence
   property p_okay;
      hreadyout && !hresp && hrdata[31:8] == 24'h00_0000;
   endproperty
   property p_wd_set;
      (wdog_zero && calm) ##1 (!rd0 && calm) ##1 rd0 |=> hrdata[BIT_WDF];
   endproperty
   property p_beat;
      s_wd_beat |=> hrdata[BIT_WDF];
   endproperty
   property p_rd_clear;
      (rd0 && quiet) ##1 s_gap_rd |=> !hrdata[BIT_WDF];
   endproperty
   property p_unmapped;
      tk && !hwrite && !hit |=> hrdata == 32'h0000_0000;
   endproperty
   property p_hold_lvl;
      wr0 ##1 1'b1 |=> write_hold == $past(hwdata[BIT_W])
                       && read_hold == $past(hwdata[BIT_R]);
   endproperty
   property p_load_pulse;
      wr0 ##1 (write_hold && !hwdata[BIT_W]) |=> hold_load ##1 !hold_load;
   endproperty
   property p_load_cause;
      hold_load |-> $past(write_hold) && !write_hold;
   endproperty
   property p_int_norm;
      !cal_r && !$past(cal_r) && $past(hresetn) |->
         int_pin == $past(int_normal);
   endproperty
   property p_sqw;
      cal_r && tog_ok_r && int_pin != int_q_r |-> cnt_r == 32'(SQW_HALF);
   endproperty
   a_okay:       assert property (p_okay)       else $error("bad response");
   a_wd_set:     assert property (p_wd_set)     else $error("wdog unset");
   a_beat:       assert property (p_beat)       else $error("set lost");
   a_rd_clear:   assert property (p_rd_clear)   else $error("no clear");
   a_unmapped:   assert property (p_unmapped)   else $error("unmapped");
   a_hold_lvl:   assert property (p_hold_lvl)   else $error("hold lvl");
   a_load_pulse: assert property (p_load_pulse) else $error("no load");
   a_load_cause: assert property (p_load_cause) else $error("stray");
   a_int_norm:   assert property (p_int_norm)   else $error("int pin");
   a_sqw:        assert property (p_sqw)        else $error("sqw half");
endmodule

bind rtcf_flags rtcf_flags_assertions #(.SQW_HALF(SQW_HALF)) chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .wdog_zero(wdog_zero), .time_now(time_now),
   .alarm_cfg(alarm_cfg), .pfail_pin(pfail_pin),
   .osc_stopped_pin(osc_stopped_pin), .int_normal(int_normal),
   .int_pin(int_pin), .write_hold(write_hold), .read_hold(read_hold),
   .hold_load(hold_load));

// file: dv/tb.sv
// self-checking bench for the rtc flags and control register
`timescale 1ns/1ps
module tb;
   import rtcf_pkg::*;
   localparam longint SQW_H = 4;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = HTRANS_IDLE;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        wdog_zero = 1'b0;
   logic [31:0] time_now = 32'h0000_0000;
   logic [31:0] alarm_cfg = 32'h8080_8080;
   logic        pfail_pin = 1'b0;
   logic        osc_stopped_pin = 1'b1;
   logic        int_normal = 1'b0;
   logic        hreadyout, hresp, int_pin, write_hold, read_hold, hold_load;
   logic [31:0] hrdata, rd;
   logic        wd_in_addr = 1'b0;
   logic        pv;
   int          fail_count = 0;
   int          tests_run = 0;
   int          n;
   always #2.5 hclk = ~hclk;
   rtcf_flags #(.SQW_HALF(SQW_H)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .wdog_zero(wdog_zero), .time_now(time_now),
      .alarm_cfg(alarm_cfg), .pfail_pin(pfail_pin),
      .osc_stopped_pin(osc_stopped_pin), .int_normal(int_normal),
      .int_pin(int_pin), .write_hold(write_hold), .read_hold(read_hold),
      .hold_load(hold_load));
   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, wd);
      @(posedge hclk);
      hsel      <= 1'b1;
      haddr     <= a;
      htrans    <= HTRANS_NONSEQ;
      hwrite    <= w;
      wdog_zero <= wd_in_addr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans    <= HTRANS_IDLE;
      hwdata    <= wd;
      wdog_zero <= 1'b0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // outputs are looked at mid-cycle, clear of the launching edge
   task automatic chko(input string nm, input logic [31:0] e,
                       ref logic s);
      @(negedge hclk);
      chk(nm, e, 32'(s));
      @(posedge hclk);
   endtask
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, e);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic pulse;
      @(posedge hclk);
      wdog_zero <= 1'b1;
      @(posedge hclk);
      wdog_zero <= 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      tick(16);
      hresetn <= 1'b1;
      tick(10);
      rdc("osc_boot", ADDR_FLAGS, 32'h0000_0010);
      osc_stopped_pin <= 1'b0;
      wr(ADDR_FLAGS, 32'h0000_0010);
      rdc("osc_keep", ADDR_FLAGS, 32'h0000_0010);
      wr(ADDR_FLAGS, 32'h0000_0000);
      rdc("osc_clr", ADDR_FLAGS, 32'h0000_0000);
      pulse();
      rdc("wdog_set", ADDR_FLAGS, 32'h0000_0080);
      rdc("wdog_clr", ADDR_FLAGS, 32'h0000_0000);
      wd_in_addr = 1'b1;
      rdc("same_edge", ADDR_FLAGS, 32'h0000_0000);
      wd_in_addr = 1'b0;
      rdc("set_wins", ADDR_FLAGS, 32'h0000_0080);
      pfail_pin <= 1'b1;
      tick(8);
      rdc("pfail_set", ADDR_FLAGS, 32'h0000_0020);
      rdc("pfail_clr", ADDR_FLAGS, 32'h0000_0000);
      wr(ADDR_FLAGS, 32'h0000_0020);
      rdc("pfail_ro", ADDR_FLAGS, 32'h0000_0000);
      pfail_pin <= 1'b0;
      time_now  <= 32'h0000_0029;
      alarm_cfg <= 32'h8080_8030;
      tick(4);
      rdc("alarm_none", ADDR_FLAGS, 32'h0000_0000);
      time_now <= 32'h0000_0030;
      tick(4);
      rdc("alarm_set", ADDR_FLAGS, 32'h0000_0040);
      rdc("alarm_clr", ADDR_FLAGS, 32'h0000_0000);
      alarm_cfg <= 32'h8080_8080;
      wr(ADDR_FLAGS, 32'h0000_0001);
      chko("read_hold", 32'h0000_0001, read_hold);
      rdc("r_bit", ADDR_FLAGS, 32'h0000_0001);
      wr(ADDR_FLAGS, 32'h0000_0002);
      chko("write_hold", 32'h0000_0001, write_hold);
      pulse();
      tick(2);
      rdc("held", ADDR_FLAGS, 32'h0000_0002);
      wr(ADDR_FLAGS, 32'h0000_0000);
      chko("hold_load", 32'h0000_0001, hold_load);
      tick(2);
      rdc("landed", ADDR_FLAGS, 32'h0000_0080);
      wr(32'h0000_0004, 32'hFFFF_FFFF);
      rdc("unmapped", 32'h0000_0004, 32'h0000_0000);
      rdc("no_alias", ADDR_FLAGS, 32'h0000_0000);
      int_normal <= 1'b1;
      tick(2);
      chko("int_follow", 32'h0000_0001, int_pin);
      int_normal <= 1'b0;
      wr(ADDR_FLAGS, 32'h0000_0004);
      n  = 0;
      pv = int_pin;
      repeat (8 * SQW_H) begin
         @(negedge hclk);
         if (int_pin !== pv) begin
            n++;
         end
         pv = int_pin;
      end
      // first half wave may be cut short by the enable timing
      chk("sqw_edges", 32'h0000_0001, 32'(n >= 7));
      rdc("cal_bit", ADDR_FLAGS, 32'h0000_0004);
      wr(ADDR_FLAGS, 32'h0000_0000);
      tick(4);
      chko("int_resume", 32'h0000_0000, int_pin);
      wr(ADDR_FLAGS, 32'h0000_0006);
      hresetn <= 1'b0;
      tick(3);
      chk("rst_hold", 32'h0000_0000, 32'(write_hold));
      hresetn <= 1'b1;
      tick(8);
      rdc("rst_val", ADDR_FLAGS, {24'h00_0000, FLAGS_RESET});
      conclude();
   end
   initial begin
      #(20000 * 5);
      fail_count++;
      conclude();
   end
endmodule

// file: hw/rtcf_alarm_cmp.sv
// alarm comparator: current time against the enabled alarm fields
`timescale 1ns/1ps
module rtcf_alarm_cmp
   import rtcf_pkg::*;
#(
   parameter int FIELDS = 4
)
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic [8*FIELDS-1:0] time_now,
   input  wire logic [8*FIELDS-1:0] alarm_cfg,
   rtcf_evt_if.alm_src              evt
);

   typedef struct packed {
      logic match;
   } rtcf_alm_st_t;

   rtcf_alm_st_t      st_r;
   rtcf_alm_st_t      st_nxt;
   logic [FIELDS-1:0] fld_ok;

   // bit 7 of each alarm byte set means that field is ignored
   genvar i;
   generate
      for (i = 0; i < FIELDS; i++) begin : g_fld
         assign fld_ok[i] = alarm_cfg[8*i+7] |
            (alarm_cfg[8*i+6 -: 7] == time_now[8*i+6 -: 7]);
      end
   endgenerate

   always_comb begin
      st_nxt       = st_r;
      // all fields masked would match forever: treat as disabled
      st_nxt.match = (&fld_ok) & ~(&alarm_cfg[8*FIELDS-1 -: 1] &
                     alarm_cfg[7] & alarm_cfg[15] & alarm_cfg[23]);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign evt.alarm_match = st_r.match;

endmodule

// file: hw/rtcf_flags.sv
// flags and control register of the rtc, ahb-lite slave
`timescale 1ns/1ps
module rtcf_flags
   import rtcf_pkg::*;
#(
   parameter longint SQW_HALF = SQW_HALF_CYC
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // event sources
   input  wire logic        wdog_zero,
   input  wire logic [31:0] time_now,
   input  wire logic [31:0] alarm_cfg,
   input  wire logic        pfail_pin,
   input  wire logic        osc_stopped_pin,
   // interrupt pin and hold controls
   input  wire logic        int_normal,
   output logic             int_pin,
   output logic             write_hold,
   output logic             read_hold,
   output logic             hold_load
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                 dph_wr;
      logic [31:0]          rdata;
      logic                 watchdog_expired_flag;
      logic                 af;
      logic                 pf;
      logic                 oscillator_fail_flag;
      logic                 cal;
      logic                 whold;
      logic                 rhold;
      logic                 pend_wdf;
      logic                 pend_af;
      logic                 pend_pf;
      logic                 match_d;
      logic                 pfail_d;
      logic [2:0]           boot_cnt;
      logic                 boot_done;
      logic [SQW_CNT_W-1:0] sq_cnt;
      logic                 sqw;
      logic                 int_out;
      logic                 load;
   } rtcf_st_t;

   rtcf_st_t st_r;
   rtcf_st_t st_nxt;

   rtcf_evt_if evt ();

   localparam logic [SQW_CNT_W-1:0] SQW_LAST =
      SQW_CNT_W'(SQW_HALF - 1);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   rtcf_sync u_sync (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .pfail_pin       (pfail_pin),
      .osc_stopped_pin (osc_stopped_pin),
      .evt             (evt.sync_src)
   );

   rtcf_alarm_cmp #(
      .FIELDS (4)
   ) u_alarm (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .time_now  (time_now),
      .alarm_cfg (alarm_cfg),
      .evt       (evt.alm_src)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic       aph;
   logic       aph_hit;
   logic       rd_hit;
   logic       wr_hit;
   logic       ev_wdf;
   logic       ev_af;
   logic       ev_pf;
   logic       set_wdf;
   logic       set_af;
   logic       set_pf;
   logic       set_oscillator_fail_flag;
   logic [7:0] flags_byte;

   assign aph     = hsel & hready & htrans[1];
   assign aph_hit = aph & (haddr[7:0] == ADDR_FLAGS);
   assign rd_hit  = aph_hit & ~hwrite;
   assign wr_hit  = st_r.dph_wr & hready;

   // ---------------------------------------------------------------
   // events
   // ---------------------------------------------------------------
   assign ev_wdf = wdog_zero;
   assign ev_af  = evt.alarm_match & ~st_r.match_d;
   assign ev_pf  = evt.pfail_lvl & ~st_r.pfail_d;

   // while write hold is set new events wait in pending bits, so
   // software loading the registers does not race the hardware
   assign set_wdf = st_r.whold ? 1'b0 : (ev_wdf | st_r.pend_wdf);
   assign set_af  = st_r.whold ? 1'b0 : (ev_af | st_r.pend_af);
   assign set_pf  = st_r.whold ? 1'b0 : (ev_pf | st_r.pend_pf);

   // oscillator pin is judged once, after the synchroniser settled
   assign set_oscillator_fail_flag = ~st_r.boot_done &
                     (st_r.boot_cnt == BOOT_CYC) &
                     evt.osc_stop_lvl;

   always_comb begin
      flags_byte           = FLAGS_RESET;
      flags_byte[BIT_WDF]  = st_r.watchdog_expired_flag;
      flags_byte[BIT_AF]   = st_r.af;
      flags_byte[BIT_PF]   = st_r.pf;
      flags_byte[BIT_OSCILLATOR_FAIL_FLAG] = st_r.oscillator_fail_flag;
      flags_byte[BIT_CAL]  = st_r.cal;
      flags_byte[BIT_W]    = st_r.whold;
      flags_byte[BIT_R]    = st_r.rhold;
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.dph_wr  = aph_hit & hwrite;
      st_nxt.match_d = evt.alarm_match;
      st_nxt.pfail_d = evt.pfail_lvl;
      st_nxt.load    = 1'b0;

      // read data captured before the clear takes effect
      if (aph & ~hwrite) begin
         st_nxt.rdata = rd_hit ? {24'h0000_00, flags_byte}
                               : 32'h0000_0000;
      end

      // clear on read first, so a set in the same cycle wins
      if (rd_hit) begin
         st_nxt.watchdog_expired_flag = 1'b0;
         st_nxt.af  = 1'b0;
         st_nxt.pf  = 1'b0;
      end

      if (st_r.whold) begin
         st_nxt.pend_wdf = st_r.pend_wdf | ev_wdf;
         st_nxt.pend_af  = st_r.pend_af | ev_af;
         st_nxt.pend_pf  = st_r.pend_pf | ev_pf;
      end else begin
         st_nxt.pend_wdf = 1'b0;
         st_nxt.pend_af  = 1'b0;
         st_nxt.pend_pf  = 1'b0;
      end

      if (wr_hit) begin
         st_nxt.cal   = hwdata[BIT_CAL];
         st_nxt.whold = hwdata[BIT_W];
         st_nxt.rhold = hwdata[BIT_R];
         // software may only clear the oscillator flag
         if (!hwdata[BIT_OSCILLATOR_FAIL_FLAG]) begin
            st_nxt.oscillator_fail_flag = 1'b0;
         end
         if (st_r.whold && !hwdata[BIT_W]) begin
            st_nxt.load = 1'b1;
         end
      end

      if (set_wdf) begin
         st_nxt.watchdog_expired_flag = 1'b1;
      end
      if (set_af) begin
         st_nxt.af = 1'b1;
      end
      if (set_pf) begin
         st_nxt.pf = 1'b1;
      end
      if (set_oscillator_fail_flag) begin
         st_nxt.oscillator_fail_flag = 1'b1;
      end

      // power-up check of the oscillator
      if (!st_r.boot_done) begin
         if (st_r.boot_cnt == BOOT_CYC) begin
            st_nxt.boot_done = 1'b1;
         end else begin
            st_nxt.boot_cnt = st_r.boot_cnt + 3'h1;
         end
      end

      // calibration square wave, reset whenever it is off
      if (!st_r.cal) begin
         st_nxt.sq_cnt = '0;
         st_nxt.sqw    = 1'b0;
      end else if (st_r.sq_cnt == SQW_LAST) begin
         st_nxt.sq_cnt = '0;
         st_nxt.sqw    = ~st_r.sqw;
      end else begin
         st_nxt.sq_cnt = st_r.sq_cnt + SQW_CNT_W'(1);
      end

      // the pin returns to its normal job as soon as cal drops
      st_nxt.int_out = st_r.cal ? st_r.sqw : int_normal;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // zero wait states: the read word is registered at the address
   // phase edge and stands through the data phase
   assign hreadyout  = 1'b1;
   assign hresp      = HRESP_OKAY;
   assign hrdata     = st_r.rdata;
   assign int_pin    = st_r.int_out;
   assign write_hold = st_r.whold;
   assign read_hold  = st_r.rhold;
   assign hold_load  = st_r.load;

endmodule

// file: hw/rtcf_sync.sv
// three-stage synchroniser for the pin inputs of the flags block
`timescale 1ns/1ps
module rtcf_sync
   import rtcf_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                pfail_pin,
   input  wire logic                osc_stopped_pin,
   rtcf_evt_if.sync_src             evt
);

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [SYNC_W-1:0] lvl;
   } rtcf_sync_st_t;

   rtcf_sync_st_t st_r;
   rtcf_sync_st_t st_nxt;
   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] lvl_nxt;

   assign pins = {osc_stopped_pin, pfail_pin};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.lvl = lvl_nxt;
   end

   // a level changes only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_lvl
         // one driver for the state copy: the loop only feeds a net
         assign lvl_nxt[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s3[i]
                                                        : st_r.lvl[i];
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign evt.pfail_lvl    = st_r.lvl[SYNC_PFAIL];
   assign evt.osc_stop_lvl = st_r.lvl[SYNC_OSC];

endmodule

// file: pkg/rtcf_evt_if.sv
// event levels passed from the helper modules to the flags register
`timescale 1ns/1ps
interface rtcf_evt_if;
   logic pfail_lvl;
   logic osc_stop_lvl;
   logic alarm_match;

   modport sync_src (output pfail_lvl, output osc_stop_lvl);
   modport alm_src  (output alarm_match);
   modport sink     (input pfail_lvl, input osc_stop_lvl,
                     input alarm_match);
endinterface

// file: pkg/rtcf_pkg.sv
// constants shared by the rtc flags and control register block
package rtcf_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADDR_FLAGS   = 8'h00;
   localparam logic [7:0]  FLAGS_RESET  = 8'h00;

   // ---------------------------------------------------------------
   // flag and control bit positions
   // ---------------------------------------------------------------
   localparam int BIT_WDF  = 7;
   localparam int BIT_AF   = 6;
   localparam int BIT_PF   = 5;
   localparam int BIT_OSCILLATOR_FAIL_FLAG = 4;
   localparam int BIT_CAL  = 2;
   localparam int BIT_W    = 1;
   localparam int BIT_R    = 0;

   // ---------------------------------------------------------------
   // ahb-lite encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam longint CLK_HZ        = 200_000_000;
   localparam longint SQW_HZ        = 512;
   // half period rounds down so the wave is never slower than asked
   localparam longint SQW_HALF_CYC  = CLK_HZ / (2 * SQW_HZ);
   localparam int     SQW_CNT_W     = $clog2(SQW_HALF_CYC + 1);
   // cycles after reset release before the oscillator pin is trusted
   localparam logic [2:0] BOOT_CYC  = 3'h5;

   // ---------------------------------------------------------------
   // synchroniser inputs
   // ---------------------------------------------------------------
   localparam int SYNC_PFAIL = 0;
   localparam int SYNC_OSC   = 1;
   localparam int SYNC_W     = 2;

endpackage
